// file: logic/cps_pkg.sv
package cps_pkg;

  // clock and timebase
  localparam int unsigned CPS_CLK_HZ      = 200_000_000;
  localparam int unsigned CPS_TICK_US     = 1000;
  localparam int unsigned CPS_TICK_CYCLES =
    (CPS_CLK_HZ / 1_000_000) * CPS_TICK_US;

  // delays in their own units, then in timebase ticks (rounded up)
  localparam int unsigned CPS_LAMP_MS     = 220;
  localparam int unsigned CPS_STOP_MS     = 400;
  localparam int unsigned CPS_RECYCLE_S   = 4;
  localparam int unsigned CPS_FLASH_MS    = 250;
  localparam int unsigned CPS_LAMP_TICKS  =
    (CPS_LAMP_MS * 1000 + CPS_TICK_US - 1) / CPS_TICK_US;
  localparam int unsigned CPS_STOP_TICKS  =
    (CPS_STOP_MS * 1000 + CPS_TICK_US - 1) / CPS_TICK_US;
  localparam int unsigned CPS_RECYCLE_TICKS =
    (CPS_RECYCLE_S * 1_000_000 + CPS_TICK_US - 1) / CPS_TICK_US;
  localparam int unsigned CPS_FLASH_TICKS =
    (CPS_FLASH_MS * 1000 + CPS_TICK_US - 1) / CPS_TICK_US;

  // register map, byte addresses
  localparam int unsigned CPS_ADDR_W      = 8;
  localparam logic [7:0]  CPS_ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  CPS_ADDR_STAT   = 8'h04;
  localparam logic [7:0]  CPS_ADDR_SENSE  = 8'h08;
  localparam int unsigned CPS_CTRL_SOFT_OFF  = 0;
  localparam int unsigned CPS_CTRL_THERM_CLR = 1;
  localparam logic        CPS_CTRL_RST       = 1'b0;

  // sensed inputs, lsb last
  typedef struct packed {
    logic bus_on_n;
    logic bus_emergency_off_n;
    logic local_switch_on;
    logic airflow_ok;
    logic door_a_closed;
    logic door_b_closed;
    logic maintenance_bypass;
    logic line_good;
    logic ac_low_warning_n;
    logic bias_return_sense;
    logic driver_power_fail_n;
  } cps_sense_t;

  // driven outputs
  typedef struct packed {
    logic contactor_drive;
    logic switched_on_lamp;
    logic thermal_lamp;
    logic stack_gen_inhibit;
    logic inhibit_drivers_off;
    logic drive_power_good;
    logic cycle_timing_reset;
  } cps_drive_t;

  localparam cps_drive_t CPS_DRIVE_RST = 7'h0D;

  // synchroniser reset: every input at its safe idle level
  localparam cps_sense_t CPS_SENSE_RST = 11'h6E1;

  typedef enum logic [2:0] {
    CPS_OFF  = 3'b001,
    CPS_ON   = 3'b010,
    CPS_STOP = 3'b100
  } cps_state_t;

endpackage : cps_pkg

// file: logic/cps_sequencer.sv
`timescale 1ns/10ps
module cps_sequencer
  import cps_pkg::*;
#(
  parameter int unsigned TICK_CYCLES   = CPS_TICK_CYCLES,
  parameter int unsigned LAMP_TICKS    = CPS_LAMP_TICKS,
  parameter int unsigned STOP_TICKS    = CPS_STOP_TICKS,
  parameter int unsigned RECYCLE_TICKS = CPS_RECYCLE_TICKS,
  parameter int unsigned FLASH_TICKS   = CPS_FLASH_TICKS
) (
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rstn_in,
  // wishbone slave
  input  wire logic                  wb_cyc_in,
  input  wire logic                  wb_stb_in,
  input  wire logic                  wb_we_in,
  input  wire logic [CPS_ADDR_W-1:0] wb_adr_in,
  input  wire logic [3:0]            wb_sel_in,
  input  wire logic [31:0]           wb_dat_in,
  output logic      [31:0]           wb_dat_out,
  output logic                       wb_ack_out,
  // cabinet sensing and drive
  input  wire cps_sense_t            sense_in,
  output cps_drive_t                 drive_out
);

  localparam int NSYNC = $bits(cps_sense_t);

  // input synchronisers
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  cps_sense_t       s;

  generate
    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
      always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          // idle levels, so no false trip just after reset
          sync_a[i] <= CPS_SENSE_RST[i];
          sync_b[i] <= CPS_SENSE_RST[i];
        end else begin
          sync_a[i] <= sense_in[i];
          sync_b[i] <= sync_a[i];
        end
      end
    end
  endgenerate

  assign s = cps_sense_t'(sync_b);

  // millisecond timebase
  logic [31:0] tick_cnt;
  logic        tick;

  assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tick_cnt <= 32'h0;
    end else if (tick) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end

  // state and registers
  cps_state_t  state;
  cps_state_t  next_state;
  cps_drive_t  next_drive;
  logic        thermal_trip_latch;
  logic        off_latch;
  logic        permit_q;
  logic        soft_off;
  logic [15:0] stop_cnt;
  logic [15:0] recycle_cnt;
  logic [15:0] lamp_cnt;
  logic [15:0] flash_cnt;
  logic        flash_phase;

  // request and permit chain
  wire bus_on        = !s.bus_on_n;
  wire emergency     = !s.bus_emergency_off_n;
  wire on_request    = bus_on && s.local_switch_on;
  wire door_open     = !(s.door_a_closed && s.door_b_closed);
  wire powered       = (state != CPS_OFF);
  wire door_trip     = door_open && powered;
  wire trip          = (thermal_trip_latch || door_trip)
                       && !s.maintenance_bypass;
  wire on_permit     = on_request && !emergency && !trip
                       && !soft_off;
  wire on_command    = off_latch && on_permit;
  wire permit_fell   = permit_q && !on_permit;
  wire stop_done     = tick && (stop_cnt == 16'(STOP_TICKS - 1));
  wire recycle_done  = tick && (recycle_cnt == 16'(RECYCLE_TICKS - 1));
  wire lamp_lit      = (lamp_cnt == 16'(LAMP_TICKS));
  wire flash_wrap    = tick && (flash_cnt == 16'(FLASH_TICKS - 1));

  // bus decode
  wire wb_req        = wb_cyc_in && wb_stb_in && !wb_ack_out;
  wire wb_wr         = wb_cyc_in && wb_stb_in && wb_ack_out && wb_we_in;
  wire sel_ctrl      = (wb_adr_in == CPS_ADDR_CTRL);
  wire sel_stat      = (wb_adr_in == CPS_ADDR_STAT);
  wire sel_sense     = (wb_adr_in == CPS_ADDR_SENSE);
  wire ctrl_wr       = wb_wr && sel_ctrl && wb_sel_in[0];
  wire therm_clr     = ctrl_wr && wb_dat_in[CPS_CTRL_THERM_CLR];
  wire [31:0] stat_word = {20'h0, state, off_latch, on_permit,
                           drive_out};
  wire [31:0] rd_mux =
    sel_ctrl  ? {31'h0, soft_off} :
    sel_stat  ? stat_word :
    sel_sense ? {{(32 - NSYNC){1'b0}}, sync_b} : 32'h0;

  // sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      CPS_OFF: begin
        if (on_command && s.line_good) begin
          next_state = CPS_ON;
        end
      end
      CPS_ON: begin
        if (!s.line_good) begin
          next_state = CPS_OFF;
        end else if (!on_permit) begin
          next_state = CPS_STOP;
        end
      end
      CPS_STOP: begin
        if (!s.line_good || stop_done) begin
          next_state = CPS_OFF;
        end
      end
    endcase
  end

  always_comb begin
    next_drive.contactor_drive     = (next_state != CPS_OFF);
    next_drive.switched_on_lamp    = lamp_lit &&
      (!s.maintenance_bypass || flash_phase);
    next_drive.thermal_lamp        = thermal_trip_latch;
    next_drive.stack_gen_inhibit   = !s.bias_return_sense ||
                                     !s.ac_low_warning_n;
    next_drive.inhibit_drivers_off = s.driver_power_fail_n ||
                                     !s.ac_low_warning_n;
    next_drive.drive_power_good    = s.ac_low_warning_n &&
                                     s.bias_return_sense;
    next_drive.cycle_timing_reset  = !s.ac_low_warning_n;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state     <= CPS_OFF;
      drive_out <= CPS_DRIVE_RST;
      permit_q  <= 1'b0;
    end else begin
      state     <= next_state;
      drive_out <= next_drive;
      permit_q  <= on_permit;
    end
  end

  // 400 ms hold before the contactor drops
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stop_cnt <= 16'h0;
    end else if (state != CPS_STOP) begin
      stop_cnt <= 16'h0;
    end else if (tick) begin
      stop_cnt <= stop_cnt + 16'h1;
    end
  end

  // off latch and recycle lockout; starts expired after reset
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      off_latch   <= 1'b1;
      recycle_cnt <= 16'h0;
    end else if (permit_fell) begin
      off_latch   <= 1'b0;
      recycle_cnt <= 16'h0;
    end else if (!off_latch) begin
      if (recycle_done) begin
        off_latch <= 1'b1;
      end
      if (tick) begin
        recycle_cnt <= recycle_cnt + 16'h1;
      end
    end
  end

  // thermal trip: a fault in the clear cycle wins
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      thermal_trip_latch <= 1'b0;
    end else if (!s.airflow_ok) begin
      thermal_trip_latch <= 1'b1;
    end else if (therm_clr) begin
      thermal_trip_latch <= 1'b0;
    end
  end

  // lamp delay, saturating; resolution is one tick
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lamp_cnt <= 16'h0;
    end else if (!s.local_switch_on) begin
      lamp_cnt <= 16'h0;
    end else if (tick && !lamp_lit) begin
      lamp_cnt <= lamp_cnt + 16'h1;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      flash_cnt   <= 16'h0;
      flash_phase <= 1'b0;
    end else if (flash_wrap) begin
      flash_cnt   <= 16'h0;
      flash_phase <= !flash_phase;
    end else if (tick) begin
      flash_cnt   <= flash_cnt + 16'h1;
    end
  end

  // register access, one wait state
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0;
      soft_off   <= CPS_CTRL_RST;
    end else begin
      wb_ack_out <= wb_req;
      wb_dat_out <= (wb_req && !wb_we_in) ? rd_mux : 32'h0;
      if (ctrl_wr) begin
        soft_off <= wb_dat_in[CPS_CTRL_SOFT_OFF];
      end
    end
  end

  // checks
  property p_bias_inhibit;
    @(posedge clk_in) disable iff (!rstn_in)
      !s.bias_return_sense |=> drive_out.stack_gen_inhibit
                               && !drive_out.drive_power_good;
  endproperty
  a_bias_inhibit: assert property (p_bias_inhibit)
    else $error("stack generators not inhibited without bias");

  property p_drv_absent;
    @(posedge clk_in) disable iff (!rstn_in)
      s.driver_power_fail_n |=> drive_out.inhibit_drivers_off;
  endproperty
  a_drv_absent: assert property (p_drv_absent)
    else $error("inhibit drivers not held off");

  property p_emergency;
    @(posedge clk_in) disable iff (!rstn_in)
      emergency |-> !on_permit ##1 (state != CPS_ON);
  endproperty
  a_emergency: assert property (p_emergency)
    else $error("emergency line did not stop the cabinet");

  property p_idle_off;
    @(posedge clk_in) disable iff (!rstn_in)
      (!bus_on && state == CPS_OFF) |=> !drive_out.contactor_drive;
  endproperty
  a_idle_off: assert property (p_idle_off)
    else $error("contactor driven with idle bus");

  property p_turn_on;
    @(posedge clk_in) disable iff (!rstn_in)
      (state == CPS_OFF && on_command && s.line_good)
        |=> state == CPS_ON && drive_out.contactor_drive;
  endproperty
  a_turn_on: assert property (p_turn_on)
    else $error("on command did not drive contactor");

  property p_latch_clear;
    @(posedge clk_in) disable iff (!rstn_in)
      permit_fell |=> !off_latch ##1 !on_command;
  endproperty
  a_latch_clear: assert property (p_latch_clear)
    else $error("off latch not cleared by permit fall");

  property p_lockout;
    @(posedge clk_in) disable iff (!rstn_in)
      (!off_latch && !recycle_done) |=> !off_latch;
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("recycle lockout ended early");

  property p_stop_hold;
    @(posedge clk_in) disable iff (!rstn_in)
      (state == CPS_STOP && s.line_good && !stop_done)
        |=> drive_out.contactor_drive;
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("contactor dropped before stop delay");

  property p_thermal;
    @(posedge clk_in) disable iff (!rstn_in)
      !s.airflow_ok |=> thermal_trip_latch ##1 drive_out.thermal_lamp;
  endproperty
  a_thermal: assert property (p_thermal)
    else $error("airflow fault not latched and shown");

  property p_ac_low;
    @(posedge clk_in) disable iff (!rstn_in)
      !s.ac_low_warning_n |=> drive_out.cycle_timing_reset
        && !drive_out.drive_power_good && drive_out.stack_gen_inhibit;
  endproperty
  a_ac_low: assert property (p_ac_low)
    else $error("ac low warning not acted on");

  property p_lamp_delay;
    @(posedge clk_in) disable iff (!rstn_in)
      !s.maintenance_bypass
        |=> drive_out.switched_on_lamp == $past(lamp_lit);
  endproperty
  a_lamp_delay: assert property (p_lamp_delay)
    else $error("switched-on lamp out of step with its delay");

  property p_switch_needed;
    @(posedge clk_in) disable iff (!rstn_in)
      (state == CPS_OFF && !s.local_switch_on)
        |=> !drive_out.contactor_drive;
  endproperty
  a_switch_needed: assert property (p_switch_needed)
    else $error("contactor driven without local switch");

  property p_release_stop;
    @(posedge clk_in) disable iff (!rstn_in)
      (state == CPS_ON && !bus_on && s.line_good)
        |=> state == CPS_STOP;
  endproperty
  a_release_stop: assert property (p_release_stop)
    else $error("released bus line did not start stopping");

  property p_thermal_off;
    @(posedge clk_in) disable iff (!rstn_in)
      (thermal_trip_latch && !s.maintenance_bypass) |-> !on_permit;
  endproperty
  a_thermal_off: assert property (p_thermal_off)
    else $error("thermal trip did not drop permit");

  property p_thermal_lamp;
    @(posedge clk_in) disable iff (!rstn_in)
      thermal_trip_latch |=> drive_out.thermal_lamp;
  endproperty
  a_thermal_lamp: assert property (p_thermal_lamp)
    else $error("thermal lamp dark with trip latched");

  property p_door_off;
    @(posedge clk_in) disable iff (!rstn_in)
      (door_open && powered && !s.maintenance_bypass) |-> !on_permit;
  endproperty
  a_door_off: assert property (p_door_off)
    else $error("open door did not drop permit");

endmodule : cps_sequencer

// file: verif/cps_bus_model.sv
`timescale 1ns/10ps
module cps_bus_model (
  // clock
  input  wire logic clk_in,
  // requests from another cabinet or the console
  input  wire logic on_req_in,
  input  wire logic emerg_in,
  // shared bus lines
  output logic      line_on_n_out,
  output logic      line_emerg_n_out
);
  // open collector with pull-up: a released line reads high, never its
  // last value
  always @(posedge clk_in) begin
    line_on_n_out    <= ~on_req_in;
    line_emerg_n_out <= ~emerg_in;
  end
endmodule : cps_bus_model

// file: verif/tb.sv
`timescale 1ns/10ps
module tb;
  import cps_pkg::*;
  logic        clk_in;
  logic        rstn_in;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat;
  logic [31:0] wb_rd;
  logic [31:0] v;
  logic        wb_ack;
  logic        on_req;
  logic        emerg;
  logic        on_n;
  logic        em_n;
  logic        lp;
  cps_sense_t  pins;
  cps_sense_t  pins_q;
  cps_sense_t  sense;
  cps_drive_t  drv;
  int          mismatches;
  int          compares;
  int          tg;

  // bus lines come from the partner, everything else from the bench
  always_comb begin
    sense                     = pins_q;
    sense.bus_on_n            = on_n;
    sense.bus_emergency_off_n = em_n;
  end

  // pin changes reach the design at a rising edge only
  always @(posedge clk_in) begin
    pins_q <= pins;
  end

  cps_bus_model u_bus (.clk_in(clk_in), .on_req_in(on_req),
    .emerg_in(emerg), .line_on_n_out(on_n), .line_emerg_n_out(em_n));

  // short counts keep each lockout near 200 cycles
  cps_sequencer #(.TICK_CYCLES(10), .LAMP_TICKS(4), .STOP_TICKS(6),
    .RECYCLE_TICKS(20), .FLASH_TICKS(3)) u_dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .wb_cyc_in(wb_cyc),
    .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
    .wb_sel_in(wb_sel), .wb_dat_in(wb_dat), .wb_dat_out(wb_rd),
    .wb_ack_out(wb_ack), .sense_in(sense), .drive_out(drv));

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task give_verdict;
    if (mismatches == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  // ends at a falling edge so outputs are settled
  task wt(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask : wt

  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_sel <= 4'hF;
    wb_dat <= d;
    // no timeout here; only the watchdog ends a wait for an ack that never comes
    do begin
      @(posedge clk_in);
    end while (wb_ack !== 1'b1);
    v = wb_rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask : wb

  task ct(input logic [31:0] exp);
    chk("contactor", 32'(drv.contactor_drive), exp);
  endtask : ct

  // timed stop: still on partway, off after the stop delay
  task stop_seq;
    wt(30);
    ct(32'h1);
    wt(50);
    ct(32'h0);
  endtask : stop_seq

  // request held through the lockout comes on once it expires
  task restart;
    wt(250);
    ct(32'h1);
  endtask : restart

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    give_verdict();
  end

  initial begin
    rstn_in = 1'b0;
    {wb_cyc, wb_stb, wb_we, on_req, emerg} = 5'h00;
    wb_adr = 8'h00;
    wb_sel = 4'hF;
    wb_dat = 32'h0;
    pins = 11'h6EE;
    mismatches = 0;
    compares = 0;
    wt(2);
    chk("reset drive", 32'(drv), 32'(CPS_DRIVE_RST));
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
    wb(1'b0, CPS_ADDR_STAT, 32'h0);
    chk("stat after reset", 32'(v[11:8]), 32'h3);
    wb(1'b0, 8'h0C, 32'h0);
    chk("unmapped read", v, 32'h0);
    wb(1'b1, CPS_ADDR_CTRL, 32'h1);
    wb(1'b0, CPS_ADDR_CTRL, 32'h0);
    chk("ctrl readback", v, 32'h1);
    wb(1'b1, CPS_ADDR_CTRL, 32'h0);
    @(posedge clk_in);
    pins.local_switch_on <= 1'b1;
    wt(20);
    chk("lamp early", 32'(drv.switched_on_lamp), 32'h0);
    wt(40);
    chk("lamp late", 32'(drv.switched_on_lamp), 32'h1);
    ct(32'h0);
    on_req <= 1'b1;
    wt(8);
    ct(32'h1);
    wb(1'b0, CPS_ADDR_STAT, 32'h0);
    chk("stat on", 32'(v[11:7]), 32'h0B);
    on_req <= 1'b0;
    stop_seq();
    on_req <= 1'b1;
    wt(90);
    ct(32'h0);
    wt(100);
    ct(32'h1);
    emerg <= 1'b1;
    stop_seq();
    wb(1'b0, CPS_ADDR_STAT, 32'h0);
    chk("off latch", 32'(v[8]), 32'h0);
    emerg <= 1'b0;
    restart();
    pins.airflow_ok <= 1'b0;
    wt(5);
    chk("thermal lamp", 32'(drv.thermal_lamp), 32'h1);
    stop_seq();
    pins.airflow_ok <= 1'b1;
    wt(4);
    wb(1'b1, CPS_ADDR_CTRL, 32'h2);
    restart();
    pins.door_a_closed <= 1'b0;
    stop_seq();
    pins.door_a_closed <= 1'b1;
    restart();
    wb(1'b1, CPS_ADDR_CTRL, 32'h1);
    stop_seq();
    wb(1'b1, CPS_ADDR_CTRL, 32'h0);
    restart();
    pins.maintenance_bypass <= 1'b1;
    wt(5);
    pins.airflow_ok    <= 1'b0;
    pins.door_b_closed <= 1'b0;
    wt(80);
    ct(32'h1);
    chk("bypass thermal", 32'(drv.thermal_lamp), 32'h1);
    tg = 0;
    lp = drv.switched_on_lamp;
    repeat (80) begin
      @(negedge clk_in);
      if (drv.switched_on_lamp !== lp) tg++;
      lp = drv.switched_on_lamp;
    end
    chk("lamp flash", 32'(tg > 1), 32'h1);
    @(posedge clk_in);
    pins.maintenance_bypass <= 1'b0;
    stop_seq();
    pins.airflow_ok    <= 1'b1;
    pins.door_b_closed <= 1'b1;
    wt(4);
    wb(1'b1, CPS_ADDR_CTRL, 32'h2);
    wt(5);
    chk("thermal clear", 32'(drv.thermal_lamp), 32'h0);
    restart();
    pins.line_good <= 1'b0;
    wt(4);
    ct(32'h0);
    pins.line_good         <= 1'b1;
    pins.bias_return_sense <= 1'b0;
    wt(4);
    chk("no bias", 32'(drv.stack_gen_inhibit), 32'h1);
    pins.bias_return_sense   <= 1'b1;
    pins.driver_power_fail_n <= 1'b1;
    wt(4);
    chk("board absent", 32'(drv.inhibit_drivers_off), 32'h1);
    chk("power good", 32'(drv.drive_power_good), 32'h1);
    chk("bias back", 32'(drv.stack_gen_inhibit), 32'h0);
    pins.driver_power_fail_n <= 1'b0;
    pins.ac_low_warning_n    <= 1'b0;
    wt(4);
    chk("ac low", 32'(drv[2:0]), 32'h5);
    give_verdict();
  end
endmodule : tb
